//--- src/pes_selector.sv
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "pes_defs.svh"

// Notes on behaviour
// [R1] A2H/04H counts scheduler-full cycles.
// [R2] A2H/08H counts store-buffers-full stall cycles.
// [R3] 10H reorder buffer full; 20H control word.
// [R4] 40H media status rename; 80H other stalls.
// [R5] A7H/01H counts queue-forced front-end resteers.
// [R6] A8H/01H counts loop replay detector micro-ops.
// [R7] B0H counts off-core requests by mask.
// [R8] B1H counts executed micro-ops per port.
// [R9] Ports 2-4 counted per core only.
// [R10] 1FH/3FH count active cycles on port groups.
// [R11] 40H ports 0,1,5; 80H ports 2,3,4.
// [R12] B2H super queue full; AEH buffer flushes.
// [R13] B3H adds pending snoops, counter 0 only.
// [R14] B8H counts hit, exclusive, modified snoop responses.
// [R15] B7H/BBH qualified by programmed auxiliary registers.
// [R16] C0H/00H retired, excluding faulting special instructions.
// [R17] C2H weighted retired micro-ops, capped at 8.
// [R18] C3H machine clear cycles, ordering, code writes.
// [R19] C4H/C5H retired and mispredicted branches by mask.
// [R20] C7H retired SIMD micro-ops by mask.
// [R21] CBH retired loads by hit level.
// [R22] Undefined selections never increment.
module pes_selector
(
  // Clock and reset.
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  // APB slave.
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [11:0]      paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic                  pready_o,
  output pes_pkg::pes_word_t    prdata_o,
  output logic                  pslverr_o,
  // Allocation stall sources, levels.
  input  wire logic             reservation_station_full_i,
  input  wire logic             store_buffers_full_i,
  input  wire logic             reorder_buffer_full_i,
  input  wire logic             fpu_control_word_stall_i,
  input  wire logic             media_control_status_stall_i,
  input  wire logic             other_stall_i,
  // Front end sources.
  input  wire logic             frontend_resteer_iq_i,
  input  wire logic [2:0]       loop_replay_detector_uops_i,
  input  wire logic             instruction_translation_buffer_flush_i,
  // Off-core request pulses.
  input  wire logic             req_demand_data_i,
  input  wire logic             req_demand_code_i,
  input  wire logic             req_demand_ownership_read_i,
  input  wire logic             req_any_read_i,
  input  wire logic             req_any_ownership_read_i,
  input  wire logic             req_l1d_writeback_i,
  input  wire logic             req_any_i,
  input  wire logic             super_queue_full_i,
  // Execution ports, one bit per port, core wide.
  input  wire logic [5:0]       port_exec_i,
  // Snoop queue and snoop responses.
  input  wire logic [3:0]       snoopq_data_pending_i,
  input  wire logic [3:0]       snoopq_inval_pending_i,
  input  wire logic [3:0]       snoopq_code_pending_i,
  input  wire logic             snoop_resp_hit_i,
  input  wire logic             snoop_resp_exclusive_hit_i,
  input  wire logic             snoop_resp_modified_line_hit_i,
  // Off-core responses with their attribute vectors.
  input  wire logic             offresp0_i,
  input  wire logic [31:0]      offresp0_attr_i,
  input  wire logic             offresp1_i,
  input  wire logic [31:0]      offresp1_attr_i,
  // Retirement.
  input  wire logic [2:0]       inst_retired_i,
  input  wire logic [2:0]       inst_retired_fault_special_i,
  input  wire logic [3:0]       uops_ret_plain_i,
  input  wire logic [3:0]       uops_ret_macro_fused_i,
  input  wire logic [3:0]       uops_ret_micro_fused_i,
  input  wire logic             machine_clear_active_i,
  input  wire logic             machine_clear_mem_order_i,
  input  wire logic             machine_clear_code_write_i,
  input  wire logic             br_ret_i,
  input  wire logic             br_ret_cond_i,
  input  wire logic             br_ret_near_call_i,
  input  wire logic             br_misp_i,
  input  wire logic             br_misp_cond_i,
  input  wire logic             br_misp_near_call_i,
  input  wire logic [4:0]       simd_ret_i,
  input  wire logic [2:0]       load_ret_i,
  // Selected increment towards the counter.
  output pes_pkg::pes_inc_t     inc_o,
  output logic                  sel_valid_o
);
  import pes_pkg::*;

  pes_word_t  select;
  pes_word_t  aux0;
  pes_word_t  aux1;
  pes_inc_t   next_inc;
  logic       next_valid;
  logic       acc;
  logic       wr_en;
  pes_word_t  rd_word;
  logic       rd_hit;

  pes_code_t  evt;
  pes_code_t  um;
  logic [2:0] ctr;
  logic       any_thr;
  logic       en;

  logic [5:0] ret_sum;

  // One-bit event as an increment.
  function automatic pes_inc_t bit_inc(input logic b);
    bit_inc = {3'h0, b};
  endfunction : bit_inc

  // Off-core response counts only when the programmed qualifier matches.
  function automatic logic resp_qual(input logic ev, input pes_word_t cfg, input pes_word_t attr);
    resp_qual = ev & (cfg != 32'h00000000) & ((cfg & attr) != 32'h00000000);
  endfunction : resp_qual

  assign evt     = select[`PES_SEL_EVT_MSB:`PES_SEL_EVT_LSB];
  assign um      = select[`PES_SEL_UM_MSB:`PES_SEL_UM_LSB];
  assign ctr     = select[`PES_SEL_CTR_MSB:`PES_SEL_CTR_LSB];
  assign any_thr = select[`PES_SEL_ANYTHR_BIT];
  assign en      = select[`PES_SEL_EN_BIT];

  // The access phase completes on the edge where the registered ready is high.
  assign acc   = psel_i & penable_i & pready_o;
  assign wr_en = acc & pwrite_i;

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      pready_o <= 1'b0;
    else
      pready_o <= psel_i & penable_i & ~pready_o;
  end

  always_comb
  begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (paddr_i)
      `PES_OFS_SELECT: rd_word = select;
      `PES_OFS_AUX0:   rd_word = aux0;
      `PES_OFS_AUX1:   rd_word = aux1;
      `PES_OFS_STATUS:
      begin
        rd_word[`PES_STA_INC_MSB:`PES_STA_INC_LSB] = inc_o;
        rd_word[`PES_STA_VALID_BIT]                = sel_valid_o;
      end
      default:         rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end
    else if (psel_i & penable_i & ~pready_o)
    begin
      prdata_o  <= pwrite_i ? 32'h00000000 : rd_word;
      pslverr_o <= ~rd_hit;
    end
    else
    begin
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      select <= `PES_RST_SELECT;
    else if (wr_en && paddr_i == `PES_OFS_SELECT)
      select <= pwdata_i & `PES_SEL_WMASK;
  end

  // Qualifier registers for the two off-core response events.
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      aux0 <= `PES_RST_AUX;
      aux1 <= `PES_RST_AUX;
    end
    else if (wr_en)
    begin
      if (paddr_i == `PES_OFS_AUX0)
        aux0 <= pwdata_i; // [R15]
      if (paddr_i == `PES_OFS_AUX1)
        aux1 <= pwdata_i; // [R15]
    end
  end

  // Weighted retire total; the inputs can exceed the per-cycle cap, so it clamps.
  assign ret_sum = {2'h0, uops_ret_plain_i} + {2'h0, uops_ret_macro_fused_i}
                 + (`PES_MICRO_WEIGHT * {2'h0, uops_ret_micro_fused_i}); // [R17]

  always_comb
  begin
    next_inc   = 4'h0;
    next_valid = 1'b1;
    case (evt)
      `PES_EV_RES_STALL:
        case (um)
          `PES_UM_B2: next_inc = bit_inc(reservation_station_full_i); // [R1]
          `PES_UM_B3: next_inc = bit_inc(store_buffers_full_i); // [R2]
          `PES_UM_B4: next_inc = bit_inc(reorder_buffer_full_i); // [R3]
          `PES_UM_B5: next_inc = bit_inc(fpu_control_word_stall_i); // [R3]
          `PES_UM_B6: next_inc = bit_inc(media_control_status_stall_i); // [R4]
          `PES_UM_B7: next_inc = bit_inc(other_stall_i); // [R4]
          default:    next_valid = 1'b0; // [R22]
        endcase
      `PES_EV_RESTEER_IQ:
        if (um == `PES_UM_B0)
          next_inc = bit_inc(frontend_resteer_iq_i); // [R5]
        else
          next_valid = 1'b0;
      `PES_EV_LOOP_UOPS:
        if (um == `PES_UM_B0)
          next_inc = {1'b0, loop_replay_detector_uops_i}; // [R6]
        else
          next_valid = 1'b0;
      `PES_EV_ITB_FLUSH:
        if (um == `PES_UM_B0)
          next_inc = bit_inc(instruction_translation_buffer_flush_i); // [R12]
        else
          next_valid = 1'b0;
      `PES_EV_OFFCORE_REQ:
        case (um)
          `PES_UM_B0: next_inc = bit_inc(req_demand_data_i); // [R7]
          `PES_UM_B1: next_inc = bit_inc(req_demand_code_i); // [R7]
          `PES_UM_B2: next_inc = bit_inc(req_demand_ownership_read_i); // [R7]
          `PES_UM_B3: next_inc = bit_inc(req_any_read_i); // [R7]
          `PES_UM_B4: next_inc = bit_inc(req_any_ownership_read_i); // [R7]
          `PES_UM_B6: next_inc = bit_inc(req_l1d_writeback_i); // [R7]
          `PES_UM_B7: next_inc = bit_inc(req_any_i); // [R7]
          default:    next_valid = 1'b0;
        endcase
      `PES_EV_UOPS_EXEC:
        case (um)
          `PES_UM_B0: next_inc = bit_inc(port_exec_i[0]); // [R8]
          `PES_UM_B1: next_inc = bit_inc(port_exec_i[1]); // [R8]
          `PES_UM_B5: next_inc = bit_inc(port_exec_i[5]); // [R8]
          `PES_UM_B2: next_inc = bit_inc(port_exec_i[2]); // [R8]
          `PES_UM_B3: next_inc = bit_inc(port_exec_i[3]); // [R8]
          `PES_UM_B4: next_inc = bit_inc(port_exec_i[4]); // [R8]
          `PES_UM_P04: next_inc = bit_inc(|port_exec_i[4:0]); // [R10]
          `PES_UM_P05: next_inc = bit_inc(|port_exec_i); // [R10]
          `PES_UM_B6:
            next_inc = bit_inc(port_exec_i[0]) + bit_inc(port_exec_i[1])
                     + bit_inc(port_exec_i[5]); // [R11]
          `PES_UM_B7:
            next_inc = bit_inc(port_exec_i[2]) + bit_inc(port_exec_i[3])
                     + bit_inc(port_exec_i[4]); // [R11]
          default:    next_valid = 1'b0;
        endcase
      `PES_EV_SQ_FULL:
        if (um == `PES_UM_B0)
          next_inc = bit_inc(super_queue_full_i); // [R12]
        else
          next_valid = 1'b0;
      `PES_EV_SNOOPQ_OUT:
        // Occupancy is only wired to one counter.
        if (ctr != `PES_SNOOP_CTR)
          next_valid = 1'b0; // [R13]
        else
          case (um)
            `PES_UM_B0: next_inc = snoopq_data_pending_i; // [R13]
            `PES_UM_B1: next_inc = snoopq_inval_pending_i; // [R13]
            `PES_UM_B2: next_inc = snoopq_code_pending_i; // [R13]
            default:    next_valid = 1'b0;
          endcase
      `PES_EV_OFFRESP0:
        if (um == `PES_UM_B0)
          next_inc = bit_inc(resp_qual(offresp0_i, aux0, offresp0_attr_i)); // [R15]
        else
          next_valid = 1'b0;
      `PES_EV_OFFRESP1:
        if (um == `PES_UM_B0)
          next_inc = bit_inc(resp_qual(offresp1_i, aux1, offresp1_attr_i)); // [R15]
        else
          next_valid = 1'b0;
      `PES_EV_SNOOP_RESP:
        case (um)
          `PES_UM_B0: next_inc = bit_inc(snoop_resp_hit_i); // [R14]
          `PES_UM_B1: next_inc = bit_inc(snoop_resp_exclusive_hit_i); // [R14]
          `PES_UM_B2: next_inc = bit_inc(snoop_resp_modified_line_hit_i); // [R14]
          default:    next_valid = 1'b0;
        endcase
      `PES_EV_INST_RET:
        if (um != `PES_UM_NONE)
          next_valid = 1'b0;
        else if (inst_retired_fault_special_i >= inst_retired_i)
          next_inc = 4'h0; // [R16]
        else
          next_inc = {1'b0, inst_retired_i - inst_retired_fault_special_i}; // [R16]
      `PES_EV_UOPS_RET:
        if (um != `PES_UM_B0)
          next_valid = 1'b0;
        else if (ret_sum > `PES_RET_CAP)
          next_inc = pes_inc_t'(`PES_RET_CAP); // [R17]
        else
          next_inc = ret_sum[3:0]; // [R17]
      `PES_EV_MCLEAR:
        case (um)
          `PES_UM_B0: next_inc = bit_inc(machine_clear_active_i); // [R18]
          `PES_UM_B1: next_inc = bit_inc(machine_clear_mem_order_i); // [R18]
          `PES_UM_B2: next_inc = bit_inc(machine_clear_code_write_i); // [R18]
          default:    next_valid = 1'b0;
        endcase
      `PES_EV_BR_RET:
        case (um)
          `PES_UM_NONE: next_inc = bit_inc(br_ret_i); // [R19]
          `PES_UM_B0:   next_inc = bit_inc(br_ret_cond_i); // [R19]
          `PES_UM_B1:   next_inc = bit_inc(br_ret_near_call_i); // [R19]
          default:      next_valid = 1'b0;
        endcase
      `PES_EV_BR_MISP:
        case (um)
          `PES_UM_NONE: next_inc = bit_inc(br_misp_i); // [R19]
          `PES_UM_B0:   next_inc = bit_inc(br_misp_cond_i); // [R19]
          `PES_UM_B1:   next_inc = bit_inc(br_misp_near_call_i); // [R19]
          `PES_UM_B2:   next_inc = bit_inc(br_misp_i); // [R19]
          default:      next_valid = 1'b0;
        endcase
      `PES_EV_SIMD_RET:
        case (um)
          `PES_UM_B0: next_inc = bit_inc(simd_ret_i[0]); // [R20]
          `PES_UM_B1: next_inc = bit_inc(simd_ret_i[1]); // [R20]
          `PES_UM_B2: next_inc = bit_inc(simd_ret_i[2]); // [R20]
          `PES_UM_B3: next_inc = bit_inc(simd_ret_i[3]); // [R20]
          `PES_UM_B4: next_inc = bit_inc(simd_ret_i[4]); // [R20]
          default:    next_valid = 1'b0;
        endcase
      `PES_EV_LOAD_RET:
        case (um)
          `PES_UM_B0: next_inc = bit_inc(load_ret_i[0]); // [R21]
          `PES_UM_B1: next_inc = bit_inc(load_ret_i[1]); // [R21]
          `PES_UM_B2: next_inc = bit_inc(load_ret_i[2]); // [R21]
          default:    next_valid = 1'b0;
        endcase
      default: next_valid = 1'b0; // [R22]
    endcase
    // Port 2 to 4 activity has no thread attribution, so a per-thread selection is refused.
    if (evt == `PES_EV_UOPS_EXEC && !any_thr &&
        (um == `PES_UM_B2 || um == `PES_UM_B3 || um == `PES_UM_B4 ||
         um == `PES_UM_P04 || um == `PES_UM_P05 || um == `PES_UM_B7))
      next_valid = 1'b0; // [R9]
    if (!next_valid || !en)
      next_inc = 4'h0; // [R22]
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      inc_o       <= `PES_RST_INC;
      sel_valid_o <= 1'b0;
    end
    else
    begin
      inc_o       <= next_inc;
      sel_valid_o <= next_valid;
    end
  end

endmodule : pes_selector

//--- src/pes_defs.svh
`ifndef PES_DEFS_SVH
`define PES_DEFS_SVH

// Register byte offsets on the APB bus.
`define PES_OFS_SELECT      12'h000
`define PES_OFS_AUX0        12'h004
`define PES_OFS_AUX1        12'h008
`define PES_OFS_STATUS      12'h00c

// Field positions of the select register.
`define PES_SEL_EVT_LSB     0
`define PES_SEL_EVT_MSB     7
`define PES_SEL_UM_LSB      8
`define PES_SEL_UM_MSB      15
`define PES_SEL_CTR_LSB     16
`define PES_SEL_CTR_MSB     18
`define PES_SEL_ANYTHR_BIT  21
`define PES_SEL_EN_BIT      22
`define PES_SEL_WMASK       32'h0067ffff

// Field positions of the status register.
`define PES_STA_INC_LSB     0
`define PES_STA_INC_MSB     3
`define PES_STA_VALID_BIT   8

// Reset values.
`define PES_RST_SELECT      32'h00000000
`define PES_RST_AUX         32'h00000000
`define PES_RST_INC         4'h0

// Event numbers.
`define PES_EV_RES_STALL    8'ha2
`define PES_EV_RESTEER_IQ   8'ha7
`define PES_EV_LOOP_UOPS    8'ha8
`define PES_EV_ITB_FLUSH    8'hae
`define PES_EV_OFFCORE_REQ  8'hb0
`define PES_EV_UOPS_EXEC    8'hb1
`define PES_EV_SQ_FULL      8'hb2
`define PES_EV_SNOOPQ_OUT   8'hb3
`define PES_EV_OFFRESP0     8'hb7
`define PES_EV_SNOOP_RESP   8'hb8
`define PES_EV_OFFRESP1     8'hbb
`define PES_EV_INST_RET     8'hc0
`define PES_EV_UOPS_RET     8'hc2
`define PES_EV_MCLEAR       8'hc3
`define PES_EV_BR_RET       8'hc4
`define PES_EV_BR_MISP      8'hc5
`define PES_EV_SIMD_RET     8'hc7
`define PES_EV_LOAD_RET     8'hcb

// Unit mask values.
`define PES_UM_NONE         8'h00
`define PES_UM_B0           8'h01
`define PES_UM_B1           8'h02
`define PES_UM_B2           8'h04
`define PES_UM_B3           8'h08
`define PES_UM_B4           8'h10
`define PES_UM_B5           8'h20
`define PES_UM_B6           8'h40
`define PES_UM_B7           8'h80
`define PES_UM_P04          8'h1f
`define PES_UM_P05          8'h3f

// Counter that alone may take snoop-queue occupancy, and retire cap.
`define PES_SNOOP_CTR       3'h0
`define PES_RET_CAP         6'h08
`define PES_MICRO_WEIGHT    6'h02

`endif

//--- src/pes_pkg.sv
package pes_pkg;
  typedef logic [3:0]  pes_inc_t;
  typedef logic [7:0]  pes_code_t;
  typedef logic [31:0] pes_word_t;
endpackage : pes_pkg

//--- verif/pes_core_model.sv
`timescale 1ns/100ps
module pes_core_model
(
  // Clock.
  input  wire logic         mclk_i,
  // Requests from the bench.
  input  wire logic         load_i,
  input  wire logic [140:0] pat_i,
  // Event source lines.
  output logic [140:0]      src_o
);
  // Every line is a one-cycle event; a level is held only by loading it again.
  always @(posedge mclk_i)
  begin
    src_o <= load_i ? pat_i : '0;
  end
endmodule : pes_core_model

//--- verif/pes_selector_asserts.sv
`timescale 1ns/100ps
module pes_selector_asserts
(
  // Clock and reset.
  input wire logic               mclk_i,
  input wire logic               rstn_i,
  // APB slave.
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic               pwrite_i,
  input wire logic [11:0]        paddr_i,
  input wire logic               pready_o,
  input wire pes_pkg::pes_word_t prdata_o,
  input wire logic               pslverr_o,
  // Selected increment.
  input wire pes_pkg::pes_inc_t  inc_o,
  input wire logic               sel_valid_o
);
  import pes_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  logic acc;
  logic sel_wr;
  assign acc = psel_i && penable_i && !pready_o;
  // A select write lands on the edge where the access phase sees ready high.
  assign sel_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h000;
  a_ready_wait: assert property (acc |=> pready_o)
    else $error("ready missing after access");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_err_unmapped: assert property (acc && paddr_i >= 12'h010 |=> pslverr_o && prdata_o == '0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr_i <= 12'h00c && paddr_i[1:0] == 2'h0 |=> !pslverr_o)
    else $error("mapped access refused");
  a_idle_quiet: assert property (!pready_o |-> prdata_o == '0 && !pslverr_o)
    else $error("bus outputs not quiet");
  a_status_read: assert property (acc && !pwrite_i && paddr_i == 12'h00c
    |=> prdata_o == {23'h0, $past(sel_valid_o), 4'h0, $past(inc_o)})
    else $error("status read mismatch");
  a_valid_change: assert property ($changed(sel_valid_o) |-> $past(sel_wr, 2))
    else $error("valid changed without select write");
  a_invalid_zero: assert property (!sel_valid_o |-> inc_o == '0)
    else $error("undefined selection counted");
endmodule : pes_selector_asserts

bind pes_selector pes_selector_asserts i_pes_selector_asserts (.*);

//--- verif/pes_selector_tb_top.sv
`timescale 1ns/100ps
`include "pes_defs.svh"
module pes_selector_tb_top;
  import pes_pkg::*;
  logic         mclk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, load = 0;
  logic [11:0]  paddr_i = '0;
  pes_word_t    pwdata_i = '0, prdata_o, rd;
  logic         pready_o, pslverr_o, sel_valid_o, er;
  pes_inc_t     inc_o;
  logic [140:0] pat = '0, src;
  int           err_total = 0, total_checks = 0, cyc = 0;
  logic         reservation_station_full_i, store_buffers_full_i, reorder_buffer_full_i,
                fpu_control_word_stall_i, media_control_status_stall_i, other_stall_i,
                frontend_resteer_iq_i, instruction_translation_buffer_flush_i,
                req_demand_data_i, req_demand_code_i, req_demand_ownership_read_i,
                req_any_read_i, req_any_ownership_read_i, req_l1d_writeback_i, req_any_i,
                super_queue_full_i, snoop_resp_hit_i, snoop_resp_exclusive_hit_i,
                snoop_resp_modified_line_hit_i, offresp0_i, offresp1_i,
                machine_clear_active_i, machine_clear_mem_order_i,
                machine_clear_code_write_i, br_ret_i, br_ret_cond_i, br_ret_near_call_i,
                br_misp_i, br_misp_cond_i, br_misp_near_call_i;
  logic [2:0]   loop_replay_detector_uops_i, inst_retired_i, inst_retired_fault_special_i,
                load_ret_i;
  logic [3:0]   snoopq_data_pending_i, snoopq_inval_pending_i, snoopq_code_pending_i,
                uops_ret_plain_i, uops_ret_macro_fused_i, uops_ret_micro_fused_i;
  logic [4:0]   simd_ret_i;
  logic [5:0]   port_exec_i;
  logic [31:0]  offresp0_attr_i, offresp1_attr_i;
  localparam logic [31:0] AT = 32'h00200000;

  assign {load_ret_i, simd_ret_i, br_misp_near_call_i, br_misp_cond_i, br_misp_i,
    br_ret_near_call_i, br_ret_cond_i, br_ret_i, machine_clear_code_write_i,
    machine_clear_mem_order_i, machine_clear_active_i, uops_ret_micro_fused_i,
    uops_ret_macro_fused_i, uops_ret_plain_i, inst_retired_fault_special_i, inst_retired_i,
    offresp1_attr_i, offresp1_i, offresp0_attr_i, offresp0_i, snoop_resp_modified_line_hit_i,
    snoop_resp_exclusive_hit_i, snoop_resp_hit_i, snoopq_code_pending_i,
    snoopq_inval_pending_i, snoopq_data_pending_i, port_exec_i, super_queue_full_i, req_any_i,
    req_l1d_writeback_i, req_any_ownership_read_i, req_any_read_i,
    req_demand_ownership_read_i, req_demand_code_i, req_demand_data_i,
    instruction_translation_buffer_flush_i, loop_replay_detector_uops_i,
    frontend_resteer_iq_i, other_stall_i, media_control_status_stall_i,
    fpu_control_word_stall_i, reorder_buffer_full_i, store_buffers_full_i,
    reservation_station_full_i} = src;

  pes_selector i_pes_selector (.*);
  pes_core_model i_pes_core_model (.mclk_i(mclk_i), .load_i(load), .pat_i(pat), .src_o(src));

  always #2.5 mclk_i = ~mclk_i;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (!ok)
    begin
      err_total++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input pes_word_t d);
    int n;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    chk(n < 20, "no ready");
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  function automatic logic [31:0] sl(input logic [7:0] ev, input logic [7:0] um);
    return 32'h00400000 | {16'h0, um, ev};
  endfunction : sl

  function automatic logic [140:0] pt(input int s, input logic [31:0] v);
    return 141'(v) << s;
  endfunction : pt

  // Selects, fires one source cycle and compares the increment one cycle later.
  task automatic probe(input logic [31:0] s, input logic [140:0] p, input pes_inc_t ei,
                       input logic ev);
    apb(1'b1, `PES_OFS_SELECT, s);
    @(posedge mclk_i);
    pat <= p;
    load <= 1'b1;
    @(posedge mclk_i);
    load <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk(inc_o === ei && sel_valid_o === ev, $sformatf("select %h", s));
  endtask : probe

  task automatic t_regs;
    apb(1'b0, `PES_OFS_SELECT, '0);
    chk(rd === `PES_RST_SELECT && er === 1'b0, "select reset");
    apb(1'b0, `PES_OFS_AUX1, '0);
    chk(rd === `PES_RST_AUX, "aux reset");
    apb(1'b0, `PES_OFS_STATUS, '0);
    chk(rd === 32'h0, "status reset");
    apb(1'b1, `PES_OFS_SELECT, 32'hffffffff);
    apb(1'b0, `PES_OFS_SELECT, '0);
    chk(rd === `PES_SEL_WMASK, "select mask");
    apb(1'b1, `PES_OFS_STATUS, 32'h1ff);
    chk(er === 1'b0, "status write");
    apb(1'b0, 12'h010, '0);
    chk(rd === 32'h0 && er === 1'b1, "unmapped");
    probe(32'h000004a2, pt(0, 1), 4'h0, 1'b1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_front;
    for (int i = 0; i < 6; i++)
      probe(sl(8'ha2, 8'h04 << i), pt(i, 1), 4'h1, 1'b1);
    probe(sl(8'ha2, 8'h04), pt(1, 1), 4'h0, 1'b1);
    probe(sl(8'ha7, 8'h01), pt(6, 1), 4'h1, 1'b1);
    probe(sl(8'ha8, 8'h01), pt(7, 5), 4'h5, 1'b1);
    probe(sl(8'hae, 8'h01), pt(10, 1), 4'h1, 1'b1);
    probe(sl(8'hb2, 8'h01), pt(18, 1), 4'h1, 1'b1);
    probe(sl(8'ha6, 8'h01), pt(6, 1), 4'h0, 1'b0);
    for (int i = 0; i < 7; i++)
      probe(sl(8'hb0, i < 5 ? 8'h01 << i : 8'h40 << (i - 5)), pt(11 + i, 1), 4'h1, 1'b1);
    probe(sl(8'hb0, 8'h01), pt(12, 32'h3f), 4'h0, 1'b1);
    probe(sl(8'hb0, 8'h20), pt(11, 32'h7f), 4'h0, 1'b0);
    $display("test front done");
  endtask : t_front

  task automatic t_ports;
    for (int i = 0; i < 6; i++)
      probe(sl(8'hb1, 8'h01 << i) | AT, pt(19 + i, 1), 4'h1, 1'b1);
    probe(sl(8'hb1, 8'h04), pt(19, 6'h04), 4'h0, 1'b0);
    probe(sl(8'hb1, 8'h1f) | AT, pt(19, 6'h03), 4'h1, 1'b1);
    probe(sl(8'hb1, 8'h1f) | AT, pt(19, 6'h20), 4'h0, 1'b1);
    probe(sl(8'hb1, 8'h3f) | AT, pt(19, 6'h20), 4'h1, 1'b1);
    probe(sl(8'hb1, 8'h40), pt(19, 6'h27), 4'h3, 1'b1);
    probe(sl(8'hb1, 8'h80) | AT, pt(19, 6'h1d), 4'h3, 1'b1);
    probe(sl(8'hb3, 8'h01), pt(25, 4'h9), 4'h9, 1'b1);
    probe(sl(8'hb3, 8'h02), pt(29, 4'hf), 4'hf, 1'b1);
    probe(sl(8'hb3, 8'h04), pt(33, 4'h7), 4'h7, 1'b1);
    probe(sl(8'hb3, 8'h01) | 32'h00010000, pt(25, 4'h9), 4'h0, 1'b0);
    for (int i = 0; i < 3; i++)
      probe(sl(8'hb8, 8'h01 << i), pt(37 + i, 1), 4'h1, 1'b1);
    $display("test ports done");
  endtask : t_ports

  task automatic t_offresp;
    apb(1'b1, `PES_OFS_AUX0, 32'h10);
    apb(1'b0, `PES_OFS_AUX0, '0);
    chk(rd === 32'h10, "aux readback");
    probe(sl(8'hb7, 8'h01), pt(40, 32'h21), 4'h1, 1'b1);
    probe(sl(8'hb7, 8'h01), pt(40, 32'h03), 4'h0, 1'b1);
    probe(sl(8'hbb, 8'h01), pt(73, 32'h09), 4'h0, 1'b1);
    apb(1'b1, `PES_OFS_AUX1, 32'h4);
    probe(sl(8'hbb, 8'h01), pt(73, 32'h09), 4'h1, 1'b1);
    $display("test offresp done");
  endtask : t_offresp

  task automatic t_retire;
    probe(sl(8'hc0, 8'h00), pt(106, 6'h15), 4'h3, 1'b1);
    probe(sl(8'hc0, 8'h00), pt(106, 6'h19), 4'h0, 1'b1);
    probe(sl(8'hc2, 8'h01), pt(112, 12'h211), 4'h6, 1'b1);
    probe(sl(8'hc2, 8'h01), pt(112, 12'h404), 4'h8, 1'b1);
    for (int i = 0; i < 3; i++)
      probe(sl(8'hc3, 8'h01 << i), pt(124 + i, 1), 4'h1, 1'b1);
    for (int i = 0; i < 6; i++)
      probe(sl(i < 3 ? 8'hc4 : 8'hc5, i % 3 == 0 ? 8'h00 : 8'h01 << (i % 3 - 1)),
            pt(127 + i, 1), 4'h1, 1'b1);
    probe(sl(8'hc5, 8'h04), pt(130, 1), 4'h1, 1'b1);
    for (int i = 0; i < 5; i++)
      probe(sl(8'hc7, 8'h01 << i), pt(133 + i, 1), 4'h1, 1'b1);
    for (int i = 0; i < 3; i++)
      probe(sl(8'hcb, 8'h01 << i), pt(138 + i, 1), 4'h1, 1'b1);
    $display("test retire done");
  endtask : t_retire

  initial
  begin
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_front();
    t_ports();
    t_offresp();
    t_retire();
    report_and_stop();
  end
endmodule : pes_selector_tb_top
